//--- design/move_pkg.sv
// Purpose: Shared constants, types and register map of the word move and convert unit
// Assumes: 10 MHz clock, APB register access, 16-bit data words
// Notes:   A 32-bit operand is two adjacent words, low word at the lower index
`default_nettype none
package move_pkg;
  // ----------------------------------------------------------------
  // Storage and limits
  // ----------------------------------------------------------------
  localparam int MEM_DEPTH = 64;
  localparam int MAX_COUNT = 512;
  localparam logic [31:0] BCD16_MAX = 32'd9999;
  localparam logic [31:0] BCD32_MAX = 32'd99999999;
  localparam logic [15:0] ERR_CODE_RANGE = 16'h0e18;
  // ----------------------------------------------------------------
  // Scan timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCAN_TIME_NS = 10000;
  localparam int SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SRC_OFS = 8'h04;
  localparam logic [7:0] DST_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] ERRCODE_OFS = 8'h14;
  localparam logic [7:0] INT_STAT_OFS = 8'h18;
  localparam logic [7:0] INT_MASK_OFS = 8'h1c;
  localparam logic [7:0] MEM_ADDR_OFS = 8'h20;
  localparam logic [7:0] MEM_DATA_OFS = 8'h24;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DWORD_BIT = 3;
  localparam int CTRL_PULSE_BIT = 4;
  localparam int CTRL_IDX2_BIT = 5;
  localparam int CTRL_SWAP_BIT = 6;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_DGT_LSB = 8;
  localparam int CTRL_W = 11;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EXEC_BIT = 1;
  localparam int ST_LATCH_BIT = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_REJ_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

  typedef enum logic [2:0] {
    OP_BLOCK_COPY, OP_FILL_COPY, OP_WORD_EXCHANGE, OP_TO_BCD, OP_TO_BIN
  } op_t;
  typedef enum logic {ST_IDLE, ST_RUN} state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;
endpackage : move_pkg
`default_nettype wire

//--- design/word_move_convert_unit.sv
// Purpose: Block copy, fill, exchange and BCD conversion over a small word store
// Assumes: Single 10 MHz clock, APB master on the same clock
// Notes:   At most one word pair is written per cycle; a scan tick paces execution
//
// Overview of operation
// - Source above destination copies upward, element by element, before overwrite.
// - Count capped at 512; writes outside the word store are dropped.
// - Fill writes one source value into n consecutive destination words.
// - Second index register addressing accepts only the 16-bit form.
// - Exchange swaps the full contents of the two named words.
// - Same word, swap select, 16-bit: swap the upper and lower bytes.
// - Same word, swap select, 32-bit: swap the two 16-bit halves.
// - Binary to BCD conversion stores packed digits in the destination.
// - BCD result out of range sets both error flags and code 0e18.
// - BCD to binary conversion stores the integer in the destination.
// - BCD source range is 0..9999 or 0..99999999 by width.
// - Invalid BCD digit sets both error flags and code 0e18.
// - Narrow destination group keeps only the low digits that fit.
// - Keep execution error, sticky latched error and last error code.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`default_nettype none
module word_move_convert_unit
  import move_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  output logic irq,
  output logic execution_error_flag,
  output logic error_latch_flag
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] mem_q [MEM_DEPTH];
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0] src_q, dst_q, cnt_q, maddr_q, err_code_q;
  logic [IRQ_W-1:0] int_q, mask_q;
  logic exec_q, latch_q, en_prev_q, pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;
  logic [10:0] step_q;
  logic [15:0] scan_q;
  state_t state_q;

  function automatic logic [15:0] rd_word(input logic [16:0] a);
    rd_word = (a < 17'(MEM_DEPTH)) ? mem_q[a[5:0]] : WORD_RST;
  endfunction : rd_word

  function automatic logic [31:0] bin2bcd(input logic [26:0] v);
    logic [31:0] b;
    b = '0;
    for (int i = 26; i >= 0; i--)
    begin
      for (int d = 0; d < 8; d++)
        if (b[d*4 +: 4] > 4'd4) b[d*4 +: 4] = b[d*4 +: 4] + 4'd3;
      b = {b[30:0], v[i]};
    end
    bin2bcd = b;
  endfunction : bin2bcd

  function automatic logic [31:0] bcd2bin(input logic [31:0] b);
    logic [31:0] acc;
    acc = '0;
    for (int d = 7; d >= 0; d--)
      acc = 32'(acc * 32'd10) + 32'(b[d*4 +: 4]);
    bcd2bin = acc;
  endfunction : bcd2bin

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire [2:0] op = ctrl_q[CTRL_OP_LSB +: 3];
  wire dword = ctrl_q[CTRL_DWORD_BIT];
  wire pulse = ctrl_q[CTRL_PULSE_BIT];
  wire idx2 = ctrl_q[CTRL_IDX2_BIT];
  wire swap = ctrl_q[CTRL_SWAP_BIT];
  wire en = ctrl_q[CTRL_EN_BIT];
  wire [2:0] dgt = ctrl_q[CTRL_DGT_LSB +: 3];
  wire same = (src_q == dst_q);
  wire asc = (src_q >= dst_q);
  wire [9:0] n_eff = (cnt_q > 16'(MAX_COUNT)) ? 10'(MAX_COUNT) : cnt_q[9:0];
  wire run = (state_q == ST_RUN);
  wire scan_tick = (scan_q == 16'(SCAN_CYCLES - 1));
  // Pulse form needs the enable seen low on the previous scan
  wire go = scan_tick && !run && en && (!pulse || !en_prev_q);
  wire reject = go && idx2 && dword;

  logic [10:0] total;
  always_comb
  begin
    unique case (op)
      OP_BLOCK_COPY: total = dword ? {n_eff, 1'b0} : {1'b0, n_eff};
      OP_FILL_COPY: total = {1'b0, n_eff};
      OP_WORD_EXCHANGE: total = (same && swap) ? 11'd1 : (dword ? 11'd2 : 11'd1);
      OP_TO_BCD, OP_TO_BIN: total = 11'd1;
      default: total = 11'd0;
    endcase
  end

  wire last = (step_q == total - 11'd1);
  wire [10:0] pos = asc ? step_q : 11'(total - 11'd1 - step_q);
  wire [16:0] src_a = {1'b0, src_q};
  wire [16:0] dst_a = {1'b0, dst_q};
  wire [16:0] fill_a = dst_a + 17'(dword ? {step_q, 1'b0} : {1'b0, step_q});

  // ----------------------------------------------------------------
  // Operand reads
  // ----------------------------------------------------------------
  logic [16:0] ra0, ra1;
  always_comb
  begin
    unique case (op)
      OP_BLOCK_COPY:
      begin
        ra0 = src_a + 17'(pos);
        ra1 = ra0;
      end
      OP_WORD_EXCHANGE:
      begin
        ra0 = src_a + 17'(step_q);
        ra1 = (same && swap) ? src_a + 17'd1 : dst_a + 17'(step_q);
      end
      default:
      begin
        ra0 = src_a;
        ra1 = src_a + 17'd1;
      end
    endcase
  end
  wire [15:0] rd0 = rd_word(ra0);
  wire [15:0] rd1 = rd_word(ra1);

  // ----------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------
  wire [31:0] val32 = dword ? {rd1, rd0} : {{16{rd0[15]}}, rd0};
  wire [31:0] bcd_in = dword ? {rd1, rd0} : {16'h0000, rd0};
  wire bcd_ovf = val32[31] || (val32 > (dword ? BCD32_MAX : BCD16_MAX));
  logic bad_digit;
  always_comb
  begin
    bad_digit = 1'b0;
    for (int d = 0; d < 8; d++)
      if (bcd_in[d*4 +: 4] > 4'd9) bad_digit = 1'b1;
  end
  wire is_bcd = (op == OP_TO_BCD);
  wire is_conv = is_bcd || (op == OP_TO_BIN);
  wire conv_err = is_conv && (is_bcd ? bcd_ovf : bad_digit);
  wire [31:0] conv_res = is_bcd ? bin2bcd(val32[26:0]) : bcd2bin(bcd_in);
  // Digit group narrower than the result keeps the bits above untouched
  wire [31:0] dmask = (dgt == 3'd0) ? 32'hffff_ffff : 32'((33'd1 << {dgt, 2'b00}) - 33'd1);
  wire [31:0] old32 = {rd_word(dst_a + 17'd1), rd_word(dst_a)};
  wire [31:0] conv_out = (old32 & ~dmask) | (conv_res & dmask);

  // ----------------------------------------------------------------
  // Write ports
  // ----------------------------------------------------------------
  logic [16:0] wa0, wa1;
  logic [15:0] wd0, wd1;
  logic we0, we1;
  always_comb
  begin
    wa0 = dst_a;
    wa1 = dst_a + 17'd1;
    wd0 = rd0;
    wd1 = rd1;
    we0 = run;
    we1 = 1'b0;
    unique case (op)
      OP_BLOCK_COPY:
        wa0 = dst_a + 17'(pos);
      OP_FILL_COPY:
      begin
        wa0 = fill_a;
        wa1 = fill_a + 17'd1;
        we1 = run && dword;
      end
      OP_WORD_EXCHANGE:
        if (same && swap && !dword)
          wd0 = {rd0[7:0], rd0[15:8]};
        else if (same && swap)
        begin
          wa0 = src_a;
          wd0 = rd1;
          wa1 = src_a + 17'd1;
          wd1 = rd0;
          we1 = run;
        end
        else
        begin
          wa0 = ra0;
          wd0 = rd1;
          wa1 = ra1;
          wd1 = rd0;
          we1 = run;
        end
      OP_TO_BCD, OP_TO_BIN:
      begin
        wd0 = conv_out[15:0];
        wd1 = conv_out[31:16];
        we0 = run && !conv_err;
        we1 = run && !conv_err && dword;
      end
      default:
        we0 = 1'b0;
    endcase
  end
  wire we0_ok = we0 && (wa0 < 17'(MEM_DEPTH));
  wire we1_ok = we1 && (wa1 < 17'(MEM_DEPTH));

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  wire acc = apb_req.psel && apb_req.penable && !pready_q;
  wire wr = apb_req.psel && apb_req.penable && pready_q && apb_req.pwrite;
  wire [7:0] addr = apb_req.paddr;
  wire [31:0] wdat = apb_req.pwdata;
  wire hit = (addr[1:0] == 2'b00) && (addr <= MEM_DATA_OFS);
  wire cfg_wr = wr && !run;
  wire bus_mem_we = cfg_wr && (addr == MEM_DATA_OFS) && (maddr_q < 16'(MEM_DEPTH));
  logic [31:0] rdata;
  always_comb
  begin
    unique case (addr)
      CTRL_OFS: rdata = 32'(ctrl_q);
      SRC_OFS: rdata = 32'(src_q);
      DST_OFS: rdata = 32'(dst_q);
      COUNT_OFS: rdata = 32'(cnt_q);
      STATUS_OFS: rdata = 32'({latch_q, exec_q, run});
      ERRCODE_OFS: rdata = 32'(err_code_q);
      INT_STAT_OFS: rdata = 32'(int_q);
      INT_MASK_OFS: rdata = 32'(mask_q);
      MEM_ADDR_OFS: rdata = 32'(maddr_q);
      MEM_DATA_OFS: rdata = 32'(rd_word({1'b0, maddr_q}));
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Events and flags
  // ----------------------------------------------------------------
  wire done_ev = run && last;
  wire err_ev = done_ev && conv_err;
  wire [IRQ_W-1:0] ev = {reject, err_ev, done_ev};
  wire [IRQ_W-1:0] int_clr = (wr && addr == INT_STAT_OFS) ? wdat[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] int_d = (int_q & ~int_clr) | ev;
  wire latch_clr = wr && (addr == STATUS_OFS) && wdat[ST_LATCH_BIT];

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      step_q <= '0;
      scan_q <= '0;
      en_prev_q <= 1'b0;
    end
    else
    begin
      scan_q <= scan_tick ? '0 : scan_q + 16'd1;
      if (scan_tick) en_prev_q <= en;
      if (go && !reject && total != 11'd0) state_q <= ST_RUN;
      else if (done_ev) state_q <= ST_IDLE;
      step_q <= (run && !last) ? step_q + 11'd1 : '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      exec_q <= 1'b0;
      latch_q <= 1'b0;
      err_code_q <= WORD_RST;
      int_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (err_ev) exec_q <= 1'b1;
      else if (done_ev) exec_q <= 1'b0;
      latch_q <= err_ev || (latch_q && !latch_clr);
      if (err_ev) err_code_q <= ERR_CODE_RANGE;
      int_q <= int_d;
      irq_q <= |(int_d & mask_q);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RST;
      {src_q, dst_q, cnt_q, maddr_q} <= '0;
      mask_q <= MASK_RST;
    end
    else if (wr)
    begin
      if (cfg_wr && addr == CTRL_OFS) ctrl_q <= wdat[CTRL_W-1:0];
      if (cfg_wr && addr == SRC_OFS) src_q <= wdat[15:0];
      if (cfg_wr && addr == DST_OFS) dst_q <= wdat[15:0];
      if (cfg_wr && addr == COUNT_OFS) cnt_q <= wdat[15:0];
      if (cfg_wr && addr == MEM_ADDR_OFS) maddr_q <= wdat[15:0];
      if (addr == INT_MASK_OFS) mask_q <= wdat[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc && !hit;
      prdata_q <= acc ? rdata : '0;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < MEM_DEPTH; i++)
      if (!rstn) mem_q[i] <= WORD_RST;
      else if (we1_ok && wa1[5:0] == 6'(i)) mem_q[i] <= wd1;
      else if (we0_ok && wa0[5:0] == 6'(i)) mem_q[i] <= wd0;
      else if (bus_mem_we && maddr_q[5:0] == 6'(i)) mem_q[i] <= wdat[15:0];
  end

  assign apb_rsp = '{pready: pready_q, prdata: prdata_q, pslverr: pslverr_q};
  assign irq = irq_q;
  assign execution_error_flag = exec_q;
  assign error_latch_flag = latch_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_conv_fail;
    run && last && conv_err;
  endsequence
  sequence s_err_shown;
    exec_q && latch_q && err_code_q == ERR_CODE_RANGE;
  endsequence
  apb_wait_one_a: assert property (acc |=> pready_q ##1 !pready_q)
    else $error("apb answer not one wait state");
  conv_error_flags_a: assert property (s_conv_fail |=> s_err_shown)
    else $error("conversion error not flagged");
  conv_no_store_a: assert property (s_conv_fail |-> !we0_ok && !we1_ok)
    else $error("failed conversion wrote result");
  latch_sticky_a: assert property (latch_q && !latch_clr |=> latch_q)
    else $error("error latch dropped");
  dword_idx2_reject_a: assert property (reject |=> !run && int_q[IRQ_REJ_BIT])
    else $error("32-bit form with second index ran");
  count_cap_a: assert property (run |-> total <= 11'(2 * MAX_COUNT) && step_q < total)
    else $error("count beyond limit");
  pulse_once_a: assert property (go && pulse |-> !en_prev_q)
    else $error("pulse form ran without enable rise");
  level_scan_a: assert property (scan_tick && en && !pulse && !run && !idx2 && total != 0
    |=> run)
    else $error("level form skipped a scan");
  byte_swap_a: assert property (run && op == OP_WORD_EXCHANGE && same && swap && !dword
    |-> wd0[7:0] == rd0[15:8] && wa0 == src_a)
    else $error("byte swap wrong");
  copy_order_a: assert property (run && op == OP_BLOCK_COPY && asc && !last
    |=> wa0 == $past(wa0) + 17'd1)
    else $error("copy order wrong");
endmodule : word_move_convert_unit
`default_nettype wire

//--- tb/step_sequencer.sv
// Purpose: Program step sequencer model issuing operations over APB
// Assumes: Same clock as the unit; answers are awaited, never counted
// Notes:   Signals change by non-blocking assignment just after a rising edge
`default_nettype none
module step_sequencer
  import move_pkg::*;
(
  input wire logic clk,
  output apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial apb_req = '0;
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    @(posedge clk);
    while (apb_rsp.pready !== 1'b1)
      @(posedge clk);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : xfer
  task automatic issue(input logic [31:0] c, input logic [31:0] s,
                       input logic [31:0] d, input logic [31:0] n);
    logic [31:0] q;
    logic e;
    // Block copies go out with the source at or above the destination
    xfer(1'b1, SRC_OFS, s, q, e);
    xfer(1'b1, DST_OFS, d, q, e);
    xfer(1'b1, COUNT_OFS, n, q, e);
    xfer(1'b1, INT_STAT_OFS, 32'h7, q, e);
    // Exchanges go out in pulse form unless a test asks for level
    xfer(1'b1, CTRL_OFS, c, q, e);
  endtask : issue
endmodule : step_sequencer
`default_nettype wire

//--- tb/test_word_move_convert_unit.sv
// Purpose: Self-checking bench of the word move and convert unit
// Assumes: 10 MHz clock; operations paced by the scan tick
// Notes:   Most operations run in pulse form so one run gives one result
`default_nettype none
module test_word_move_convert_unit
  import move_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rstn;
  apb_req_t req;
  apb_rsp_t rsp;
  logic irq;
  logic execution_error_flag;
  logic error_latch_flag;
  int bad_count;
  int check_count;
  logic [31:0] q;
  logic e;

  word_move_convert_unit i_word_move_convert_unit (.clk(clk), .rstn(rstn),
    .apb_req(req), .apb_rsp(rsp), .irq(irq),
    .execution_error_flag(execution_error_flag), .error_latch_flag(error_latch_flag));
  step_sequencer i_step_sequencer (.clk(clk), .apb_req(req), .apb_rsp(rsp));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
      bad_count++;
    end
  endtask : chk_bit
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_step_sequencer.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_step_sequencer.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic mem_wr(input logic [31:0] a, input logic [31:0] d);
    wr(MEM_ADDR_OFS, a);
    wr(MEM_DATA_OFS, d);
  endtask : mem_wr
  task automatic mem_chk(input logic [31:0] a, input logic [31:0] x);
    wr(MEM_ADDR_OFS, a);
    rd(MEM_DATA_OFS);
    chk(q, x);
  endtask : mem_chk
  function automatic logic [31:0] ctl(input op_t op, input logic dw, input logic sw,
                                      input logic ix, input logic [2:0] g);
    return {21'h0, g, 1'b1, sw, ix, 1'b1, dw, op};
  endfunction : ctl
  task automatic wait_done;
    int k;
    k = 0;
    rd(INT_STAT_OFS);
    while (q[2:0] === 3'h0 && k < 400)
    begin
      rd(INT_STAT_OFS);
      k++;
    end
    if (k >= 400)
      chk_bit(1'b1, 1'b0);
  endtask : wait_done
  // Pulse form, then enable dropped for a full scan so the next rise counts
  task automatic run(input logic [31:0] c, input logic [31:0] s, input logic [31:0] d,
                     input logic [31:0] n);
    i_step_sequencer.issue(c, s, d, n);
    wait_done();
    wr(CTRL_OFS, 32'h0);
    repeat (SCAN_CYCLES + 10) @(posedge clk);
  endtask : run
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 10; i++)
    begin
      rd(8'(4 * i));
      chk(q, 32'h0);
    end
    rd(8'h28);
    chk_bit(e, 1'b1);
    chk(q, 32'h0);
    rd(8'h02);
    chk_bit(e, 1'b1);
  endtask : t_reset
  task automatic t_move;
    for (int i = 0; i < 4; i++)
      mem_wr(i + 2, i + 1);
    run(ctl(OP_BLOCK_COPY, 0, 0, 0, 0), 2, 0, 4);
    for (int i = 0; i < 4; i++)
      mem_chk(i, i + 1);
    mem_wr(1, 16'h00a5);
    run(ctl(OP_FILL_COPY, 0, 0, 0, 0), 1, 10, 5);
    for (int i = 10; i < 15; i++)
      mem_chk(i, 16'h00a5);
    mem_chk(15, 32'h0);
    run(ctl(OP_FILL_COPY, 0, 0, 0, 0), 1, 60, 600);
    mem_chk(63, 16'h00a5);
    mem_chk(0, 32'h1);
    mem_wr(50, 16'h1111);
    run(ctl(OP_FILL_COPY, 1, 0, 1, 0), 1, 50, 1);
    rd(INT_STAT_OFS);
    chk(q, 32'h4);
    mem_chk(50, 16'h1111);
    run(ctl(OP_FILL_COPY, 0, 0, 1, 0), 1, 50, 1);
    mem_chk(50, 16'h00a5);
  endtask : t_move
  task automatic t_exch;
    mem_wr(20, 16'h1234);
    mem_wr(40, 16'hbeef);
    run(ctl(OP_WORD_EXCHANGE, 0, 0, 0, 0), 20, 40, 1);
    mem_chk(20, 16'hbeef);
    mem_chk(40, 16'h1234);
    run(ctl(OP_WORD_EXCHANGE, 0, 1, 0, 0), 20, 20, 1);
    mem_chk(20, 16'hefbe);
    mem_wr(30, 16'h1234);
    mem_wr(31, 16'h5678);
    run(ctl(OP_WORD_EXCHANGE, 1, 1, 0, 0), 30, 30, 1);
    mem_chk(30, 16'h5678);
    mem_chk(31, 16'h1234);
    i_step_sequencer.issue(ctl(OP_WORD_EXCHANGE, 0, 0, 0, 0), 20, 40, 1);
    wait_done();
    wr(INT_STAT_OFS, 32'h7);
    repeat (3 * SCAN_CYCLES) @(posedge clk);
    rd(INT_STAT_OFS);
    chk(q, 32'h0);
    i_step_sequencer.issue(ctl(OP_WORD_EXCHANGE, 0, 0, 0, 0) & ~32'h10, 20, 40, 1);
    wait_done();
    wr(INT_STAT_OFS, 32'h7);
    repeat (3 * SCAN_CYCLES) @(posedge clk);
    rd(INT_STAT_OFS);
    chk(q, 32'h1);
    // A write that lands in a busy cycle is dropped, so retry until enable reads back low
    do
    begin
      wr(CTRL_OFS, 32'h0);
      rd(CTRL_OFS);
    end
    while (q !== 32'h0);
    repeat (SCAN_CYCLES + 10) @(posedge clk);
  endtask : t_exch
  task automatic t_conv;
    mem_wr(10, 16'd1234);
    run(ctl(OP_TO_BCD, 0, 0, 0, 0), 10, 11, 1);
    mem_chk(11, 16'h1234);
    mem_wr(12, 16'h614e);
    mem_wr(13, 16'h00bc);
    run(ctl(OP_TO_BCD, 1, 0, 0, 0), 12, 14, 1);
    mem_chk(14, 16'h5678);
    mem_chk(15, 16'h1234);
    mem_wr(10, 16'h001e);
    mem_wr(16, 16'habcf);
    run(ctl(OP_TO_BCD, 0, 0, 0, 3'd1), 10, 16, 1);
    mem_chk(16, 16'habc0);
    mem_wr(10, 16'd10000);
    run(ctl(OP_TO_BCD, 0, 0, 0, 0), 10, 17, 1);
    mem_chk(17, 32'h0);
    rd(STATUS_OFS);
    chk(q, 32'h6);
    rd(ERRCODE_OFS);
    chk(q, 32'(ERR_CODE_RANGE));
    chk_bit(irq, 1'b0);
    wr(INT_MASK_OFS, 32'h2);
    // The new mask reaches the interrupt flop one clock after the write lands
    repeat (2) @(negedge clk);
    chk_bit(irq, 1'b1);
    wr(INT_STAT_OFS, 32'h2);
    @(negedge clk);
    chk_bit(irq, 1'b0);
    mem_wr(10, 16'd9999);
    run(ctl(OP_TO_BCD, 0, 0, 0, 0), 10, 17, 1);
    mem_chk(17, 16'h9999);
    chk_bit(execution_error_flag, 1'b0);
    chk_bit(error_latch_flag, 1'b1);
    wr(STATUS_OFS, 32'h4);
    @(negedge clk);
    chk_bit(error_latch_flag, 1'b0);
  endtask : t_conv
  task automatic t_bin;
    mem_wr(10, 16'h9999);
    run(ctl(OP_TO_BIN, 0, 0, 0, 0), 10, 18, 1);
    mem_chk(18, 16'd9999);
    mem_wr(20, 16'h9999);
    mem_wr(21, 16'h9999);
    run(ctl(OP_TO_BIN, 1, 0, 0, 0), 20, 22, 1);
    mem_chk(22, 16'he0ff);
    mem_chk(23, 16'h05f5);
    mem_wr(10, 16'h12a4);
    run(ctl(OP_TO_BIN, 0, 0, 0, 0), 10, 24, 1);
    mem_chk(24, 32'h0);
    rd(STATUS_OFS);
    chk(q, 32'h6);
    rd(ERRCODE_OFS);
    chk(q, 32'(ERR_CODE_RANGE));
    chk_bit(irq, 1'b1);
  endtask : t_bin
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    bad_count = 0;
    check_count = 0;
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_move();
    t_exch();
    t_conv();
    t_bin();
    end_of_test();
  end
endmodule : test_word_move_convert_unit
`default_nettype wire
